/* File: hw/bcd_pkg.sv */
package bcd_pkg;

  // --------------------------------------------------------------
  // configuration word layout
  // --------------------------------------------------------------
  localparam int CFG_W      = 16;
  localparam int F_RTC_FULL = 0;
  localparam int F_CLK_RC   = 1;
  localparam int F_KEEP_ON  = 2;
  localparam int F_SLOT_LNG = 3;
  localparam int F_LP_OFF   = 4;
  localparam int F_LP_RST   = 5;
  localparam int F_INTERRUPT_POLARITY   = 6;
  localparam int F_SUP_MSK  = 7;
  localparam int F_P5_FALL  = 8;
  localparam int F_P5_RISE  = 9;
  localparam int F_P4_FALL  = 10;
  localparam int F_P4_RISE  = 11;
  localparam int F_OPEN_DR  = 12;
  localparam int F_WD_EN    = 13;
  localparam int F_AUTO_ON  = 14;
  localparam int F_PD_POL   = 15;

  // --------------------------------------------------------------
  // fixed boot values
  // --------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_FIXED       = 16'h65B8;
  localparam logic [7:0]       VER_FIXED       = 8'h20;
  localparam int               SLOT_W          = 4;
  localparam logic [3:0]       SLOT_NONE       = 4'h0;
  localparam logic [3:0]       SLOT_FIRST      = 4'h1;
  localparam logic [3:0]       SLOT_LAST       = 4'hF;
  localparam logic [3:0]       FIX_RST_SLOT    = 4'hE;
  localparam logic [3:0]       FIX_PIN0_SLOT   = 4'h5;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam longint CLK_HZ         = 40000000;
  localparam longint SLOT_SHORT_US  = 500;
  localparam longint SLOT_LONG_US   = 2000;
  localparam longint WD_PERIOD_S    = 100;
  localparam longint SLOT_SHORT_CYC = SLOT_SHORT_US * CLK_HZ / 1000000;
  localparam longint SLOT_LONG_CYC  = SLOT_LONG_US * CLK_HZ / 1000000;
  localparam longint WD_PERIOD_CYC  = WD_PERIOD_S * CLK_HZ;
  localparam int     SLOT_CNT_W     = 17;
  localparam int     WD_CNT_W       = 32;

  // --------------------------------------------------------------
  // synchronised pin positions
  // --------------------------------------------------------------
  localparam int SY_W      = 6;
  localparam int SY_STRAP  = 0;
  localparam int SY_PIN4   = 1;
  localparam int SY_PIN5   = 2;
  localparam int SY_HOLD   = 3;
  localparam int SY_PDN    = 4;
  localparam int SY_SUPPLY = 5;

  typedef enum logic [1:0] {ST_LOAD, ST_OFF, ST_SEQ, ST_ON} bcd_state_e;

endpackage

/* File: hw/bcd_sync.sv */
module bcd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys_in,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage feeds only the second stage
  // no reset: the strap must already be settled when reset lets go
  always_ff @(posedge clk_sys_in)
  begin
    meta_r <= async_in;
    sync_r <= meta_r;
  end

  assign sync_out = sync_r;

endmodule

/* File: hw/bcd_top.sv */
// Functional notes
// [RULE1] slot lasts 0.5 ms or 2 ms
// [RULE2] interrupt output polarity follows polarity bit
// [RULE3] long press turns off when enabled
// [RULE4] core reset after long-press turn-off when enabled
// [RULE5] slow clock from crystal or RC
// [RULE6] rtc regulator low or full power when off
// [RULE7] keep-on bit holds device on
// [RULE8] supply rise auto-starts unless masked
// [RULE9] mask bits gate pin four/five edge events
// [RULE10] fixed boot masks falls, passes rises
// [RULE11] pin zero push-pull or open-drain
// [RULE12] watchdog runs 100 s period when enabled
// [RULE13] readable boot version, fixed 0x20
// [RULE14] auto keep-on sets bit, hold pin freed
// [RULE15] power-down input polarity selectable
// [RULE16] power-up steps slots enabling resources
module bcd_top #(
  parameter logic [16:0] SLOT_SHORT_CYC = 17'(bcd_pkg::SLOT_SHORT_CYC),
  parameter logic [16:0] SLOT_LONG_CYC  = 17'(bcd_pkg::SLOT_LONG_CYC),
  parameter logic [31:0] WD_PERIOD_CYC  = 32'(bcd_pkg::WD_PERIOD_CYC)
) (
  input  wire logic        clk_sys_in,
  input  wire logic        nrst_in,
  input  wire logic        boot_from_eeprom_in,
  input  wire logic [15:0] eeprom_cfg_in,
  input  wire logic [7:0]  eeprom_version_in,
  input  wire logic [3:0]  eeprom_reset_slot_in,
  input  wire logic [3:0]  eeprom_pin0_slot_in,
  input  wire logic        host_wr_in,
  input  wire logic [15:0] host_cfg_in,
  input  wire logic        start_reason_in,
  input  wire logic        supply_present_in,
  input  wire logic        long_press_in,
  input  wire logic        power_hold_pin_in,
  input  wire logic        power_down_reset_input_in,
  input  wire logic        general_pin_four_in,
  input  wire logic        general_pin_five_in,
  input  wire logic        pin0_level_in,
  input  wire logic        irq_req_in,
  input  wire logic        wd_kick_in,
  output logic [15:0]      cfg_out,
  output logic [7:0]       boot_sequence_version_out,
  output logic [3:0]       slot_num_out,
  output logic             keep_on_bit_out,
  output logic             system_reset_out_n_out,
  output logic             general_pin_zero_out,
  output logic             general_pin_zero_oe_out,
  output logic             interrupt_out,
  output logic [3:0]       pin_event_out,
  output logic             turn_off_req_out,
  output logic             core_reset_out,
  output logic             rtc_full_power_out,
  output logic             slow_clk_rc_out,
  output logic             power_hold_gpi_out,
  output logic             watchdog_expire_out
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [bcd_pkg::SY_W-1:0] sy;

  bcd_sync #(.W(bcd_pkg::SY_W)) u_sync (
    .clk_sys_in (clk_sys_in),
    .async_in   ({supply_present_in, power_down_reset_input_in, power_hold_pin_in,
                  general_pin_five_in, general_pin_four_in, boot_from_eeprom_in}),
    .sync_out   (sy)
  );

  // ----------------------------------------------------------------
  // state and configuration
  // ----------------------------------------------------------------
  bcd_pkg::bcd_state_e state_r, state_nxt;
  logic [15:0] cfg_r, cfg_nxt;
  logic [7:0]  ver_r, ver_nxt;
  logic [3:0]  rst_slot_r, rst_slot_nxt;
  logic [3:0]  pin0_slot_r, pin0_slot_nxt;
  logic [3:0]  slot_r, slot_nxt;
  logic [16:0] slot_cnt_r, slot_cnt_nxt;
  logic [31:0] wd_cnt_r, wd_cnt_nxt;
  logic        rst_pend_r, rst_pend_nxt;
  logic        sup_prev_r, p4_prev_r, p5_prev_r;
  logic        rst_rel_r, rst_rel_nxt;
  logic        pin0_en_r, pin0_en_nxt;
  logic        core_rst_r, core_rst_nxt;
  logic        off_req_r, off_req_nxt;
  logic        wd_exp_r, wd_exp_nxt;
  logic        irq_r, irq_nxt;
  logic        pz_r, pz_nxt;
  logic        pz_oe_r, pz_oe_nxt;
  logic [3:0]  ev_r, ev_nxt;
  logic [16:0] slot_lim;
  logic        slot_tick, pd_act, hold_ok, sup_rise, lp_off_ev, auto_set;

  always_comb
  begin
    slot_lim  = cfg_r[bcd_pkg::F_SLOT_LNG] ? SLOT_LONG_CYC - 17'h1
                                           : SLOT_SHORT_CYC - 17'h1; // RULE1
    slot_tick = (state_r == bcd_pkg::ST_SEQ) && (slot_cnt_r == slot_lim);
    // polarity option: 0 active-low, 1 active-high
    pd_act    = cfg_r[bcd_pkg::F_PD_POL] ? sy[bcd_pkg::SY_PDN]
                                         : !sy[bcd_pkg::SY_PDN]; // RULE15
    // hold pin only counts while auto keep-on is off
    hold_ok   = cfg_r[bcd_pkg::F_KEEP_ON]
                || (!cfg_r[bcd_pkg::F_AUTO_ON] && sy[bcd_pkg::SY_HOLD]); // RULE7 RULE14
    sup_rise  = sy[bcd_pkg::SY_SUPPLY] && !sup_prev_r;
    lp_off_ev = (state_r == bcd_pkg::ST_ON) && long_press_in
                && cfg_r[bcd_pkg::F_LP_OFF]; // RULE3
    auto_set  = slot_tick && (slot_r == bcd_pkg::SLOT_LAST)
                && cfg_r[bcd_pkg::F_AUTO_ON]; // RULE14
  end

  always_comb
  begin
    state_nxt     = state_r;
    cfg_nxt       = cfg_r;
    ver_nxt       = ver_r;
    rst_slot_nxt  = rst_slot_r;
    pin0_slot_nxt = pin0_slot_r;
    slot_nxt      = slot_r;
    slot_cnt_nxt  = slot_cnt_r;
    rst_pend_nxt  = rst_pend_r;
    rst_rel_nxt   = rst_rel_r;
    pin0_en_nxt   = pin0_en_r;
    core_rst_nxt  = 1'b0;
    off_req_nxt   = 1'b0;
    if (host_wr_in)
    begin
      cfg_nxt = host_cfg_in;
    end
    unique case (state_r)
      bcd_pkg::ST_LOAD:
      begin
        // fixed values unless the strap selects the stored image
        if (sy[bcd_pkg::SY_STRAP])
        begin
          cfg_nxt       = eeprom_cfg_in;
          ver_nxt       = eeprom_version_in;
          rst_slot_nxt  = eeprom_reset_slot_in;
          pin0_slot_nxt = eeprom_pin0_slot_in;
        end
        else
        begin
          cfg_nxt       = bcd_pkg::CFG_FIXED; // RULE10
          ver_nxt       = bcd_pkg::VER_FIXED; // RULE13
          rst_slot_nxt  = bcd_pkg::FIX_RST_SLOT;
          pin0_slot_nxt = bcd_pkg::FIX_PIN0_SLOT;
        end
        rst_pend_nxt = 1'b0;
        state_nxt    = bcd_pkg::ST_OFF;
      end
      bcd_pkg::ST_OFF:
      begin
        rst_rel_nxt = 1'b0;
        pin0_en_nxt = 1'b0;
        if (rst_pend_r)
        begin
          core_rst_nxt = 1'b1; // RULE4
          state_nxt    = bcd_pkg::ST_LOAD;
        end
        else if (start_reason_in || (sup_rise && !cfg_r[bcd_pkg::F_SUP_MSK])) // RULE8
        begin
          state_nxt    = bcd_pkg::ST_SEQ;
          slot_nxt     = bcd_pkg::SLOT_FIRST;
          slot_cnt_nxt = '0;
        end
      end
      bcd_pkg::ST_SEQ:
      begin
        // resource comes up at its own slot and stays up
        if (slot_r == rst_slot_r && rst_slot_r != bcd_pkg::SLOT_NONE)
        begin
          rst_rel_nxt = 1'b1; // RULE16
        end
        if (slot_r == pin0_slot_r && pin0_slot_r != bcd_pkg::SLOT_NONE)
        begin
          pin0_en_nxt = 1'b1; // RULE16
        end
        slot_cnt_nxt = slot_cnt_r + 17'h1;
        if (pd_act)
        begin
          state_nxt = bcd_pkg::ST_LOAD;
        end
        else if (slot_tick)
        begin
          slot_cnt_nxt = '0;
          if (slot_r == bcd_pkg::SLOT_LAST)
          begin
            state_nxt = bcd_pkg::ST_ON;
          end
          else
          begin
            slot_nxt = slot_r + 4'h1; // RULE16
          end
        end
      end
      bcd_pkg::ST_ON:
      begin
        if (pd_act)
        begin
          state_nxt = bcd_pkg::ST_LOAD; // RULE15
        end
        else if (lp_off_ev)
        begin
          off_req_nxt  = 1'b1; // RULE3
          rst_pend_nxt = cfg_r[bcd_pkg::F_LP_RST]; // RULE4
          state_nxt    = bcd_pkg::ST_OFF;
        end
        else if (!hold_ok)
        begin
          state_nxt = bcd_pkg::ST_OFF; // RULE7
        end
      end
    endcase
    if (state_nxt == bcd_pkg::ST_OFF && state_r == bcd_pkg::ST_ON)
    begin
      cfg_nxt[bcd_pkg::F_KEEP_ON] = 1'b0;
    end
    // internal set beats a host clear in the same cycle
    if (auto_set)
    begin
      cfg_nxt[bcd_pkg::F_KEEP_ON] = 1'b1; // RULE14
    end
  end

  // ----------------------------------------------------------------
  // watchdog, pins, interrupt output
  // ----------------------------------------------------------------
  always_comb
  begin
    wd_cnt_nxt = '0;
    wd_exp_nxt = 1'b0;
    if (state_r == bcd_pkg::ST_ON && cfg_r[bcd_pkg::F_WD_EN] && !wd_kick_in)
    begin
      if (wd_cnt_r == WD_PERIOD_CYC - 32'h1)
      begin
        wd_exp_nxt = 1'b1; // RULE12
      end
      else
      begin
        wd_cnt_nxt = wd_cnt_r + 32'h1; // RULE12
      end
    end
    // masked edges never reach the event lines
    ev_nxt[0] = !sy[bcd_pkg::SY_PIN4] && p4_prev_r && !cfg_r[bcd_pkg::F_P4_FALL]; // RULE9
    ev_nxt[1] = sy[bcd_pkg::SY_PIN4] && !p4_prev_r && !cfg_r[bcd_pkg::F_P4_RISE]; // RULE9
    ev_nxt[2] = !sy[bcd_pkg::SY_PIN5] && p5_prev_r && !cfg_r[bcd_pkg::F_P5_FALL]; // RULE9
    ev_nxt[3] = sy[bcd_pkg::SY_PIN5] && !p5_prev_r && !cfg_r[bcd_pkg::F_P5_RISE]; // RULE9
    irq_nxt   = cfg_r[bcd_pkg::F_INTERRUPT_POLARITY] ? irq_req_in : !irq_req_in; // RULE2
    pz_nxt    = 1'b0;
    pz_oe_nxt = 1'b0;
    if (pin0_en_r)
    begin
      if (cfg_r[bcd_pkg::F_OPEN_DR])
      begin
        pz_oe_nxt = !pin0_level_in; // RULE11
      end
      else
      begin
        pz_nxt    = pin0_level_in; // RULE11
        pz_oe_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_r     <= bcd_pkg::ST_LOAD;
      cfg_r       <= bcd_pkg::CFG_FIXED;
      ver_r       <= bcd_pkg::VER_FIXED;
      rst_slot_r  <= bcd_pkg::FIX_RST_SLOT;
      pin0_slot_r <= bcd_pkg::FIX_PIN0_SLOT;
      slot_r      <= bcd_pkg::SLOT_NONE;
      slot_cnt_r  <= '0;
      wd_cnt_r    <= '0;
      rst_pend_r  <= 1'b0;
      sup_prev_r  <= 1'b0;
      p4_prev_r   <= 1'b0;
      p5_prev_r   <= 1'b0;
      rst_rel_r   <= 1'b0;
      pin0_en_r   <= 1'b0;
      core_rst_r  <= 1'b0;
      off_req_r   <= 1'b0;
      wd_exp_r    <= 1'b0;
      irq_r       <= 1'b1;
      pz_r        <= 1'b0;
      pz_oe_r     <= 1'b0;
      ev_r        <= '0;
    end
    else
    begin
      state_r     <= state_nxt;
      cfg_r       <= cfg_nxt;
      ver_r       <= ver_nxt;
      rst_slot_r  <= rst_slot_nxt;
      pin0_slot_r <= pin0_slot_nxt;
      slot_r      <= slot_nxt;
      slot_cnt_r  <= slot_cnt_nxt;
      wd_cnt_r    <= wd_cnt_nxt;
      rst_pend_r  <= rst_pend_nxt;
      sup_prev_r  <= sy[bcd_pkg::SY_SUPPLY];
      p4_prev_r   <= sy[bcd_pkg::SY_PIN4];
      p5_prev_r   <= sy[bcd_pkg::SY_PIN5];
      rst_rel_r   <= rst_rel_nxt;
      pin0_en_r   <= pin0_en_nxt;
      core_rst_r  <= core_rst_nxt;
      off_req_r   <= off_req_nxt;
      wd_exp_r    <= wd_exp_nxt;
      irq_r       <= irq_nxt;
      pz_r        <= pz_nxt;
      pz_oe_r     <= pz_oe_nxt;
      ev_r        <= ev_nxt;
    end
  end

  assign cfg_out                   = cfg_r;
  assign boot_sequence_version_out = ver_r; // RULE13
  assign slot_num_out              = slot_r;
  assign keep_on_bit_out                = cfg_r[bcd_pkg::F_KEEP_ON];
  assign system_reset_out_n_out    = rst_rel_r;
  assign general_pin_zero_out      = pz_r;
  assign general_pin_zero_oe_out   = pz_oe_r;
  assign interrupt_out             = irq_r;
  assign pin_event_out             = ev_r;
  assign turn_off_req_out          = off_req_r;
  assign core_reset_out            = core_rst_r;
  assign rtc_full_power_out        = cfg_r[bcd_pkg::F_RTC_FULL]; // RULE6
  assign slow_clk_rc_out           = cfg_r[bcd_pkg::F_CLK_RC]; // RULE5
  assign power_hold_gpi_out        = cfg_r[bcd_pkg::F_AUTO_ON]; // RULE14
  assign watchdog_expire_out       = wd_exp_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);

  slot_len_a: assert property ((state_r == bcd_pkg::ST_SEQ) && $changed(slot_r) // RULE1
    && $past(state_r) == bcd_pkg::ST_SEQ |->
    $past(slot_cnt_r) == $past(slot_lim)) else $error("slot ended early");
  int_pol_a: assert property (irq_req_in && !host_wr_in |=> // RULE2
    interrupt_out == $past(cfg_r[bcd_pkg::F_INTERRUPT_POLARITY])) else $error("interrupt level wrong");
  lp_off_a: assert property (lp_off_ev && !pd_act |=> // RULE3
    state_r == bcd_pkg::ST_OFF && turn_off_req_out) else $error("long press ignored");
  core_rst_a: assert property (lp_off_ev && !pd_act && cfg_r[bcd_pkg::F_LP_RST] |=> ##1 // RULE4
    core_reset_out && state_r == bcd_pkg::ST_LOAD) else $error("core reset missing");
  clk_src_a: assert property (host_wr_in && state_r != bcd_pkg::ST_LOAD |=> // RULE5
    slow_clk_rc_out == $past(host_cfg_in[bcd_pkg::F_CLK_RC])) else $error("clock source");
  keep_on_a: assert property (state_r == bcd_pkg::ST_ON && cfg_r[bcd_pkg::F_KEEP_ON] // RULE7
    && !pd_act && !lp_off_ev |=> state_r == bcd_pkg::ST_ON) else $error("dropped while held");
  auto_on_a: assert property (state_r == bcd_pkg::ST_OFF && !rst_pend_r && sup_rise // RULE8
    && !cfg_r[bcd_pkg::F_SUP_MSK] |=> state_r == bcd_pkg::ST_SEQ) else $error("no auto on");
  pin_mask_a: assert property (|(ev_r & $past({cfg_r[bcd_pkg::F_P5_RISE], // RULE9
    cfg_r[bcd_pkg::F_P5_FALL], cfg_r[bcd_pkg::F_P4_RISE], cfg_r[bcd_pkg::F_P4_FALL]}))
    == 1'b0) else $error("masked edge passed");
  fixed_load_a: assert property (state_r == bcd_pkg::ST_LOAD && !sy[bcd_pkg::SY_STRAP] // RULE10
    && !auto_set |=> cfg_r == bcd_pkg::CFG_FIXED && ver_r == bcd_pkg::VER_FIXED)
    else $error("fixed boot load");
  open_drain_a: assert property (general_pin_zero_oe_out && // RULE11
    $past(cfg_r[bcd_pkg::F_OPEN_DR]) |-> !general_pin_zero_out) else $error("od drives high");
  wd_run_a: assert property (watchdog_expire_out |-> $past(cfg_r[bcd_pkg::F_WD_EN]) // RULE12
    && $past(state_r) == bcd_pkg::ST_ON) else $error("watchdog fired while off");
  auto_keep_a: assert property (auto_set && !pd_act |=> cfg_r[bcd_pkg::F_KEEP_ON] // RULE14
    && state_r == bcd_pkg::ST_ON) else $error("keep-on not set");
  pd_pol_a: assert property (state_r == bcd_pkg::ST_ON && pd_act |=> // RULE15
    state_r == bcd_pkg::ST_LOAD) else $error("power-down ignored");
  rst_slot_a: assert property (state_r == bcd_pkg::ST_SEQ && slot_r == rst_slot_r // RULE16
    && rst_slot_r != bcd_pkg::SLOT_NONE |=> system_reset_out_n_out)
    else $error("reset not released");

  seq_done_c: cover property (state_r == bcd_pkg::ST_SEQ ##1 state_r == bcd_pkg::ST_ON);
  lp_rst_c: cover property (core_reset_out);
  edge_c: cover property (|pin_event_out);
  wd_c: cover property (watchdog_expire_out);

endmodule

/* File: test/bcd_partner.sv */
module bcd_partner (
  input  wire logic       clk_sys_in,
  input  wire logic       slow_in,
  input  wire logic [1:0] toggle_in,
  input  wire logic       pdn_req_in,
  input  wire logic       pdn_pol_in,
  output logic            pin_four_out,
  output logic            pin_five_out,
  output logic            pdn_out
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] toggle_d;

  initial
  begin
    pin_four_out = 1'b0;
    pin_five_out = 1'b0;
    toggle_d     = 2'h0;
  end

  // slow mode answers a cycle late, as a sluggish board would
  always @(posedge clk_sys_in)
  begin
    toggle_d <= toggle_in;
    if (slow_in ? toggle_d[0] : toggle_in[0])
      pin_four_out <= ~pin_four_out;
    if (slow_in ? toggle_d[1] : toggle_in[1])
      pin_five_out <= ~pin_five_out;
  end

  // request means asserted; level follows the configured polarity
  assign pdn_out = pdn_pol_in ? pdn_req_in : ~pdn_req_in;
endmodule

/* File: test/boot_control_defaults_bench.sv */
module boot_control_defaults_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  localparam logic [15:0] ON_CFG = bcd_pkg::CFG_FIXED | 16'h0004;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in    = 1'b0;
  logic        strap      = 1'b0;
  logic [15:0] ee_cfg     = 16'h0000;
  logic [7:0]  ee_ver     = 8'h00;
  logic [7:0]  ee_slots   = 8'h00;
  logic        host_wr    = 1'b0;
  logic [15:0] host_cfg   = 16'h0000;
  logic        start      = 1'b0;
  logic        supply     = 1'b0;
  logic        lp         = 1'b0;
  logic        pin0_lvl   = 1'b1;
  logic        irq_req    = 1'b0;
  logic        wd_kick    = 1'b1;
  logic [1:0]  tog        = 2'h0;
  logic        pdn_req    = 1'b0;
  logic        slow       = 1'b0;
  logic        hold       = 1'b0;
  logic [15:0] cfg, w;
  logic [7:0]  ver;
  logic [3:0]  slot, pev;
  logic        keep_on_bit, rst_n, g0, g0_oe, irq, toff, creset, rtc, rc, gpi, wdx, p4, p5, pdn;
  integer      fail_count = 0, num_checks = 0, seed = 2, cycles = 0, n, i, len;
  logic [5:0]  notes[$];

  bcd_top #(.SLOT_SHORT_CYC(17'h4), .SLOT_LONG_CYC(17'h8), .WD_PERIOD_CYC(32'h10)) uut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .boot_from_eeprom_in(strap),
    .eeprom_cfg_in(ee_cfg), .eeprom_version_in(ee_ver),
    .eeprom_reset_slot_in(ee_slots[3:0]), .eeprom_pin0_slot_in(ee_slots[7:4]),
    .host_wr_in(host_wr), .host_cfg_in(host_cfg), .start_reason_in(start),
    .supply_present_in(supply), .long_press_in(lp), .power_hold_pin_in(hold),
    .power_down_reset_input_in(pdn), .general_pin_four_in(p4), .general_pin_five_in(p5),
    .pin0_level_in(pin0_lvl), .irq_req_in(irq_req), .wd_kick_in(wd_kick),
    .cfg_out(cfg), .boot_sequence_version_out(ver), .slot_num_out(slot),
    .keep_on_bit_out(keep_on_bit), .system_reset_out_n_out(rst_n), .general_pin_zero_out(g0),
    .general_pin_zero_oe_out(g0_oe), .interrupt_out(irq), .pin_event_out(pev),
    .turn_off_req_out(toff), .core_reset_out(creset), .rtc_full_power_out(rtc),
    .slow_clk_rc_out(rc), .power_hold_gpi_out(gpi), .watchdog_expire_out(wdx));

  bcd_partner partner (.clk_sys_in(clk_sys_in), .slow_in(slow), .toggle_in(tog),
    .pdn_req_in(pdn_req), .pdn_pol_in(cfg[15]), .pin_four_out(p4), .pin_five_out(p5),
    .pdn_out(pdn));

  initial
    forever #12.5 clk_sys_in = ~clk_sys_in;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys_in);
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // strap must be steady before release, it is synchronised
  task automatic do_reset(input logic s);
    nrst_in <= 1'b0;
    strap   <= s;
    step(12);
    nrst_in <= 1'b1;
    step(2);
  endtask

  task automatic wr(input logic [15:0] v);
    step(1);
    host_wr  <= 1'b1;
    host_cfg <= v;
    step(1);
    host_wr  <= 1'b0;
    step(2);
  endtask

  task automatic pwr_up;
    step(1);
    start <= 1'b1;
    step(1);
    start <= 1'b0;
  endtask

  task automatic pulse_lp;
    step(1);
    lp <= 1'b1;
    step(1);
    lp <= 1'b0;
    step(10);
    @(negedge clk_sys_in);
  endtask

  // one-cycle pulses are judged against the oldest note
  always @(negedge clk_sys_in)
    if ({toff, creset, pev} !== 6'h00)
    begin
      if (notes.size() == 0)
        chk("stray event", 16'({toff, creset, pev}), 16'h0000);
      else
        chk("event", 16'({toff, creset, pev}), 16'(notes.pop_front()));
    end

  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial
  begin
    for (i = 0; i < 3; i++)
    begin
      ee_cfg   <= 16'($random(seed));
      ee_ver   <= 8'($random(seed));
      ee_slots <= 8'($random(seed));
      do_reset(i != 0);
      @(negedge clk_sys_in);
      w = (i != 0) ? ee_cfg : bcd_pkg::CFG_FIXED;
      chk("cfg", cfg, w);
      chk("version", 16'(ver), 16'((i != 0) ? ee_ver : bcd_pkg::VER_FIXED));
      chk("rtc mode", 16'(rtc), 16'(w[0]));
      chk("clk src", 16'(rc), 16'(w[1]));
      chk("hold gpi", 16'(gpi), 16'(w[14]));
    end
    $display("load done");
    for (i = 0; i < 2; i++)
    begin
      len = i ? 8 : 4;
      do_reset(1'b0);
      if (i == 0)
        wr(bcd_pkg::CFG_FIXED & ~16'h0008);
      pwr_up();
      @(negedge clk_sys_in);
      chk("first slot", 16'(slot), 16'h0001);
      n = 0;
      while (slot === 4'h1 && n < 50)
      begin
        @(negedge clk_sys_in);
        n++;
      end
      chk("slot len", 16'(n), 16'(len));
      n = 0;
      while (rst_n !== 1'b1 && n < 400)
      begin
        @(negedge clk_sys_in);
        n++;
      end
      chk("reset slot", 16'(slot), 16'(bcd_pkg::FIX_RST_SLOT));
      step(2 * len + 4);
      @(negedge clk_sys_in);
      chk("auto on", 16'(keep_on_bit), 16'h0001);
      chk("pin0 oe", 16'({g0, g0_oe}), 16'h0003);
    end
    $display("power-up done");
    wr(ON_CFG | 16'h1000);
    @(negedge clk_sys_in);
    chk("od high", 16'(g0_oe), 16'h0000);
    step(1);
    pin0_lvl <= 1'b0;
    step(3);
    @(negedge clk_sys_in);
    chk("od low", 16'({g0, g0_oe}), 16'h0001);
    step(1);
    irq_req <= 1'b1;
    step(2);
    @(negedge clk_sys_in);
    chk("irq low", 16'(irq), 16'h0000);
    wr(ON_CFG | 16'h0040);
    @(negedge clk_sys_in);
    chk("irq high", 16'(irq), 16'h0001);
    step(1);
    irq_req <= 1'b0;
    step(2);
    @(negedge clk_sys_in);
    chk("irq idle", 16'(irq), 16'h0000);
    $display("pins done");
    for (i = 0; i < 8; i++)
    begin
      w = i[2] ? (ON_CFG ^ 16'h0F00) : ON_CFG;
      if (i == 4)
        wr(w);
      slow <= i[2];
      if (!w[8 + {~i[1], ~i[0]}])
        notes.push_back(6'(1 << {i[1], ~i[0]}));
      step(1);
      tog <= 2'(1 << i[1]);
      step(1);
      tog <= 2'h0;
      step(10);
    end
    chk("events left", 16'(notes.size()), 16'h0000);
    $display("edges done");
    step(1);
    wd_kick <= 1'b0;
    n = 0;
    while (wdx !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk("wd period", 16'(n >= 14 && n <= 17), 16'h0001);
    wr(ON_CFG & ~16'h2030);
    n = 0;
    repeat (40)
    begin
      @(negedge clk_sys_in);
      n += (wdx === 1'b1);
    end
    chk("wd off", 16'(n), 16'h0000);
    $display("watchdog done");
    pulse_lp();
    chk("lp ignored", 16'(rst_n), 16'h0001);
    wr(ON_CFG & ~16'h2000);
    notes.push_back(6'h20);
    notes.push_back(6'h10);
    pulse_lp();
    chk("lp off", 16'(rst_n), 16'h0000);
    $display("long press done");
    pwr_up();
    step(15 * 8 + 4);
    @(negedge clk_sys_in);
    chk("on", 16'(rst_n), 16'h0001);
    step(1);
    pdn_req <= 1'b1;
    step(8);
    @(negedge clk_sys_in);
    chk("pdn", 16'(rst_n), 16'h0000);
    step(1);
    pdn_req <= 1'b0;
    $display("power-down done");
    do_reset(1'b0);
    step(1);
    supply <= 1'b1;
    step(10);
    @(negedge clk_sys_in);
    chk("masked start", 16'(slot), 16'h0000);
    wr(bcd_pkg::CFG_FIXED & ~16'h0080);
    supply <= 1'b0;
    step(4);
    supply <= 1'b1;
    n = 0;
    while (slot === 4'h0 && n < 10)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    chk("auto start", 16'(slot), 16'h0001);
    step(1);
    hold <= 1'b1;
    wr(bcd_pkg::CFG_FIXED & ~16'h4080);
    step(15 * 8 + 4);
    @(negedge clk_sys_in);
    chk("hold on", 16'({rst_n, keep_on_bit}), 16'h0002);
    step(1);
    hold <= 1'b0;
    step(6);
    @(negedge clk_sys_in);
    chk("hold off", 16'(rst_n), 16'h0000);
    $display("auto start done");
    final_report();
  end
endmodule
